/* design/flash_ctrl_pkg.sv */
// Package for the flash read buffer controller: register map, fields, resets, timing.
// Assumes a 40 MHz system branch clock and a 128-bit flash array on the same clock.
package flash_ctrl_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int T_INIT_NS = 150000;
  localparam int INIT_CYCLES = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAIT = 8'h04;
  localparam logic [7:0] OFS_PADDR = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_SECURE = 8'h14;
  localparam logic [7:0] OFS_LATCH0 = 8'h20;
  localparam logic [7:0] OFS_LATCH3 = 8'h2C;

  localparam int CTRL_ASYNC_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_PSS_BIT = 3;
  localparam int CMD_BURN_BIT = 0;
  localparam int CMD_ERASE_BIT = 1;
  localparam int ST_BURN_BIT = 0;
  localparam int ST_ERASE_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_INIT_BIT = 3;
  localparam int ST_JTAG_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;
  localparam int IDX_JTAG_BIT = 0;
  localparam int IDX_SEC_LSB = 1;

  localparam int NUM_SECTORS = 19;
  localparam int WORD_AW = 16;
  localparam logic [WORD_AW-1:0] INDEX_WORD_ADDR = 16'h0000;
  localparam logic [19:0] SMALL_REGION_END = 20'h1_0000;
  localparam logic [31:0] FLASH_BASE = 32'h2000_0000;
  localparam logic [3:0] WAIT_RESET = 4'h3;

  typedef enum logic [1:0] {BUF_NONE, BUF_SINGLE, BUF_DUAL_ONE_SPEC, BUF_DUAL_ALWAYS} buf_mode_t;

  typedef struct packed {
    logic async_timing;
    buf_mode_t mode;
    logic protection_sector_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{async_timing: 1'b0, mode: BUF_SINGLE, protection_sector_select: 1'b0};

  typedef struct packed {
    logic rd;
    logic abort;
    logic prog;
    logic erase;
    logic index;
    logic [WORD_AW-1:0] addr;
    logic [127:0] wdata;
  } flash_req_t;

endpackage

/* design/flash_read_buffer_controller.sv */
// Flash controller core: AHB read port with buffer lines, APB configuration, array sequencing.
// Assumes the array answers reads after the programmed wait states and pulses done for burn/erase.
//
// Function
// - After reset run initialisation for the init time, stalling AHB flash transfers.
// - During initialisation read the protection sector for access protection and security.
// - Active access protection blocks debug-port flash access and processor debug.
// - With sector security, reads of secured sectors return no contents.
// - Synchronous timing: reads run to completion, no speculation, no dual line.
// - Asynchronous timing: reads can be aborted, enabling speculation and dual lines.
// - A buffer line holds a full 128-bit word serving four 32-bit words.
// - Without buffering every AHB read outside a secured sector launches a new array read.
// - Single line: same-word reads are served from the buffer with no wait.
// - A different word starts an array read with wait states until data arrives.
// - Dual mode copies the primary hit word to the second line, then prefetches.
// - Invalidate both lines after init, config access, latch read, protection read.
// - Reset mode is synchronous timing with a single buffer line.
// - Dual single-speculative: a miss is followed by at most one speculative read.
// - Dual always-speculative: copy used word, start next sequential read immediately.
// - Eight 8 kB sectors from the base, then up to eleven 64 kB sectors.
// - Pages of 32 words; a sector is erased before being written.
// - Protection-sector select maps that sector over flash; if found programmed when read at initialisation it is not erasable.
// - Above three wait states speculation cannot give zero-wait reads.
// - Burn and erase completion raise the interrupt; no suspension is offered.
`timescale 1ns/10ps
`default_nettype none

module flash_read_buffer_controller
  import flash_ctrl_pkg::*;
#(
  parameter int INIT_COUNT = flash_ctrl_pkg::INIT_CYCLES
) (
  input wire logic clk_i, // System branch clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic hsel_i, // AHB slave select.
  input wire logic [31:0] haddr_i, // AHB address.
  input wire logic [1:0] htrans_i, // AHB transfer type.
  input wire logic hwrite_i, // AHB write flag.
  input wire logic hready_i, // AHB bus ready.
  output logic [31:0] hrdata_o, // AHB read data.
  output logic hready_o, // AHB slave ready.
  output logic hresp_o, // AHB response, always OKAY.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB write.
  input wire logic [7:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error for unmapped address or command write while busy.
  output flash_ctrl_pkg::flash_req_t flash_o, // Array request bundle.
  input wire logic [127:0] flash_rdata_i, // Array read word.
  input wire logic flash_done_i, // Array burn or erase finished.
  output logic jtag_block_o, // Debug-port flash access refused.
  output logic debug_disable_o, // Processor debug disabled.
  output logic irq_o // Burn or erase finished.
);
  import flash_ctrl_pkg::*;

  typedef enum {S_INIT, S_INDEX, S_IDLE, S_READ, S_PROG} state_t;

  state_t state;
  logic [31:0] init_cnt;
  logic [3:0] rd_cnt;
  logic rd_spec;
  logic [WORD_AW-1:0] rd_addr;
  logic [127:0] p_data;
  logic [WORD_AW-1:0] p_addr;
  logic p_valid;
  logic [127:0] s_data;
  logic [WORD_AW-1:0] s_addr;
  logic s_valid;
  logic spec_left;
  logic pend;
  logic [WORD_AW-1:0] pend_addr;
  logic [1:0] pend_sel;
  logic pend_secure;
  logic [NUM_SECTORS-1:0] secure;
  logic jtag_prot;
  logic index_programmed;
  logic init_done;
  ctrl_t ctrl;
  logic [3:0] read_wait_states;
  logic [31:0] prog_addr;
  logic [31:0] latch [4];
  logic cmd_burn;
  logic cmd_erase;
  logic cmd_ack;
  logic burn_done_evt;
  logic erase_done_evt;
  logic erase_refused_evt;
  logic inval;
  logic [5:0] status;

  // Sector number as counted from the base: 0..7 small, 8.. large.
  function automatic logic [4:0] sector_of(input logic [19:0] ofs);
    if (ofs < SMALL_REGION_END) begin
      return {2'b00, ofs[15:13]};
    end
    return 5'd7 + {1'b0, ofs[19:16]};
  endfunction

  function automatic logic [31:0] word_pick(input logic [127:0] w, input logic [1:0] sel);
    return w[sel*32 +: 32];
  endfunction

  logic take;
  logic [WORD_AW-1:0] a_word;
  logic [1:0] a_sel;
  logic a_secure;
  logic dual;
  logic async_ok;
  logic use_buf;
  logic hit_p;
  logic hit_s;

  always_comb begin
    take = hsel_i && htrans_i[1] && hready_i && hready_o && !hwrite_i;
    a_word = haddr_i[WORD_AW+3:4];
    a_sel = haddr_i[3:2];
    a_secure = secure[sector_of(haddr_i[19:0])] && !ctrl.protection_sector_select;
    async_ok = ctrl.async_timing;
    dual = async_ok && (ctrl.mode == BUF_DUAL_ONE_SPEC || ctrl.mode == BUF_DUAL_ALWAYS);
    use_buf = (ctrl.mode != BUF_NONE) && !ctrl.protection_sector_select;
    hit_p = use_buf && p_valid && (p_addr == a_word) && !(state == S_READ && rd_spec && rd_addr == a_word);
    hit_s = use_buf && dual && s_valid && (s_addr == a_word);
  end

  // Read path, buffer lines and array sequencing share one owner of the array.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_INIT;
      init_cnt <= '0;
      rd_cnt <= '0;
      rd_spec <= 1'b0;
      rd_addr <= '0;
      p_data <= '0;
      p_addr <= '0;
      p_valid <= 1'b0;
      s_data <= '0;
      s_addr <= '0;
      s_valid <= 1'b0;
      spec_left <= 1'b0;
      pend <= 1'b0;
      pend_addr <= '0;
      pend_sel <= '0;
      pend_secure <= 1'b0;
      secure <= '0;
      jtag_prot <= 1'b0;
      index_programmed <= 1'b0;
      init_done <= 1'b0;
      hrdata_o <= '0;
      hready_o <= 1'b1;
      flash_o <= '0;
      cmd_ack <= 1'b0;
      burn_done_evt <= 1'b0;
      erase_done_evt <= 1'b0;
      erase_refused_evt <= 1'b0;
    end else begin
      flash_o.abort <= 1'b0;
      cmd_ack <= 1'b0;
      burn_done_evt <= 1'b0;
      erase_done_evt <= 1'b0;
      erase_refused_evt <= 1'b0;
      if (inval) begin
        p_valid <= 1'b0;
        s_valid <= 1'b0;
      end
      if (take) begin
        if (!init_done) begin
          hready_o <= 1'b0;
          pend <= 1'b1;
          pend_addr <= a_word;
          pend_sel <= a_sel;
          pend_secure <= a_secure;
        end else if (a_secure) begin
          hrdata_o <= '0;
          hready_o <= 1'b1;
        end else if (hit_p) begin
          hrdata_o <= word_pick(p_data, a_sel);
          hready_o <= 1'b1;
          if (dual && state == S_IDLE && (ctrl.mode == BUF_DUAL_ALWAYS || spec_left)) begin
            // Prefetch pays off only with few wait states.
            s_data <= p_data;
            s_addr <= p_addr;
            s_valid <= 1'b1;
            spec_left <= 1'b0;
            state <= S_READ;
            rd_spec <= 1'b1;
            rd_addr <= p_addr + 1'b1;
            rd_cnt <= read_wait_states;
            flash_o.rd <= 1'b1;
            flash_o.addr <= p_addr + 1'b1;
          end
        end else if (hit_s) begin
          hrdata_o <= word_pick(s_data, a_sel);
          hready_o <= 1'b1;
        end else begin
          hready_o <= 1'b0;
          pend <= 1'b1;
          pend_addr <= a_word;
          pend_sel <= a_sel;
          pend_secure <= 1'b0;
          spec_left <= (ctrl.mode == BUF_DUAL_ONE_SPEC);
          if (state == S_READ && async_ok) begin
            flash_o.abort <= 1'b1;
            flash_o.rd <= 1'b0;
            state <= S_IDLE;
          end
        end
      end
      case (state)
        S_INIT: begin
          if (init_cnt >= INIT_COUNT - 1) begin
            state <= S_INDEX;
            rd_cnt <= read_wait_states;
            flash_o.rd <= 1'b1;
            flash_o.index <= 1'b1;
            flash_o.addr <= INDEX_WORD_ADDR;
          end else begin
            init_cnt <= init_cnt + 32'd1;
          end
        end
        S_INDEX: begin
          if (rd_cnt == '0) begin
            jtag_prot <= flash_rdata_i[IDX_JTAG_BIT];
            secure <= flash_rdata_i[IDX_SEC_LSB +: NUM_SECTORS];
            index_programmed <= ~&flash_rdata_i;
            init_done <= 1'b1;
            p_valid <= 1'b0;
            s_valid <= 1'b0;
            flash_o.rd <= 1'b0;
            flash_o.index <= 1'b0;
            state <= S_IDLE;
          end else begin
            rd_cnt <= rd_cnt - 4'd1;
          end
        end
        S_IDLE: begin
          // A read stalled by start-up was taken before the security bits were known.
          if (pend && (pend_secure || (secure[sector_of({pend_addr, 4'h0})] && !ctrl.protection_sector_select))) begin
            hrdata_o <= '0;
            hready_o <= 1'b1;
            pend <= 1'b0;
          end else if (pend && !take) begin
            state <= S_READ;
            rd_spec <= 1'b0;
            rd_addr <= pend_addr;
            rd_cnt <= read_wait_states;
            flash_o.rd <= 1'b1;
            flash_o.index <= ctrl.protection_sector_select;
            flash_o.addr <= pend_addr;
          end else if (cmd_burn && !take) begin
            state <= S_PROG;
            cmd_ack <= 1'b1;
            flash_o.prog <= 1'b1;
            flash_o.index <= ctrl.protection_sector_select;
            flash_o.addr <= prog_addr[WORD_AW+3:4];
            flash_o.wdata <= {latch[3], latch[2], latch[1], latch[0]};
            p_valid <= 1'b0;
            s_valid <= 1'b0;
          end else if (cmd_erase && !take) begin
            cmd_ack <= 1'b1;
            if (ctrl.protection_sector_select && index_programmed) begin
              erase_refused_evt <= 1'b1;
            end else begin
              state <= S_PROG;
              flash_o.erase <= 1'b1;
              flash_o.index <= ctrl.protection_sector_select;
              flash_o.addr <= prog_addr[WORD_AW+3:4];
              p_valid <= 1'b0;
              s_valid <= 1'b0;
            end
          end
        end
        S_READ: begin
          if (!(take && !hit_p && !hit_s && !a_secure && async_ok)) begin
            if (rd_cnt == '0) begin
              flash_o.rd <= 1'b0;
              flash_o.index <= 1'b0;
              state <= S_IDLE;
              p_data <= flash_rdata_i;
              p_addr <= rd_addr;
              p_valid <= use_buf && !inval;
              if (ctrl.protection_sector_select) begin
                s_valid <= 1'b0;
              end
              if (pend && pend_addr == rd_addr) begin
                hrdata_o <= word_pick(flash_rdata_i, pend_sel);
                hready_o <= 1'b1;
                pend <= 1'b0;
              end
            end else begin
              rd_cnt <= rd_cnt - 4'd1;
            end
          end
        end
        S_PROG: begin
          // Burn and erase run to the end; there is no suspend path.
          if (flash_done_i) begin
            burn_done_evt <= flash_o.prog;
            erase_done_evt <= flash_o.erase;
            flash_o.prog <= 1'b0;
            flash_o.erase <= 1'b0;
            flash_o.index <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Protection outcome drives the debug path.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      jtag_block_o <= 1'b0;
      debug_disable_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      jtag_block_o <= jtag_prot;
      debug_disable_o <= jtag_prot;
      hresp_o <= 1'b0;
    end
  end

  logic setup;
  logic wr_now;
  logic cmd_busy;
  logic [4:0] latch_idx;

  always_comb begin
    setup = psel_i && !penable_i;
    wr_now = setup && pwrite_i;
    cmd_busy = cmd_burn || cmd_erase || state == S_PROG;
    latch_idx = paddr_i[6:2] - OFS_LATCH0[6:2];
  end

  // APB slave: answers in the first access cycle; writes act at the setup edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RESET;
      read_wait_states <= WAIT_RESET;
      prog_addr <= FLASH_BASE;
      for (int i = 0; i < 4; i++) begin
        latch[i] <= '0;
      end
      cmd_burn <= 1'b0;
      cmd_erase <= 1'b0;
      inval <= 1'b0;
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      inval <= 1'b0;
      pready_o <= setup;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
      if (cmd_ack) begin
        cmd_burn <= 1'b0;
        cmd_erase <= 1'b0;
      end
      if (setup) begin
        if (paddr_i == OFS_CTRL) begin
          inval <= 1'b1;
          // Field order follows the register layout, not the packing of the struct.
          prdata_o <= {28'h000_0000, ctrl.protection_sector_select, ctrl.mode, ctrl.async_timing};
          if (pwrite_i) begin
            ctrl.async_timing <= pwdata_i[CTRL_ASYNC_BIT];
            ctrl.mode <= buf_mode_t'(pwdata_i[CTRL_MODE_LSB +: 2]);
            ctrl.protection_sector_select <= pwdata_i[CTRL_PSS_BIT];
          end
        end else if (paddr_i == OFS_WAIT) begin
          inval <= 1'b1;
          prdata_o <= {28'h000_0000, read_wait_states};
          if (pwrite_i) begin
            read_wait_states <= pwdata_i[3:0];
          end
        end else if (paddr_i == OFS_PADDR) begin
          inval <= 1'b1;
          prdata_o <= prog_addr;
          if (pwrite_i) begin
            prog_addr <= pwdata_i;
          end
        end else if (paddr_i == OFS_CMD) begin
          if (wr_now && cmd_busy) begin
            pslverr_o <= 1'b1;
          end else if (wr_now) begin
            cmd_burn <= pwdata_i[CMD_BURN_BIT];
            cmd_erase <= pwdata_i[CMD_ERASE_BIT] && !pwdata_i[CMD_BURN_BIT];
          end
        end else if (paddr_i == OFS_STATUS) begin
          prdata_o <= {26'h000_0000, status};
        end else if (paddr_i == OFS_SECURE) begin
          prdata_o <= {13'h0000, secure};
        end else if (paddr_i >= OFS_LATCH0 && paddr_i <= OFS_LATCH3 && paddr_i[1:0] == 2'b00) begin
          prdata_o <= latch[latch_idx[1:0]];
          if (pwrite_i) begin
            latch[latch_idx[1:0]] <= pwdata_i;
          end else begin
            inval <= 1'b1;
          end
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= '0;
      irq_o <= 1'b0;
    end else begin
      status[ST_BUSY_BIT] <= cmd_busy;
      status[ST_INIT_BIT] <= init_done;
      status[ST_JTAG_BIT] <= jtag_prot;
      for (int b = ST_BURN_BIT; b <= ST_ERASE_BIT; b++) begin
        if (wr_now && paddr_i == OFS_STATUS && pwdata_i[b]) begin
          status[b] <= 1'b0;
        end
      end
      if (wr_now && paddr_i == OFS_STATUS && pwdata_i[ST_REFUSED_BIT]) begin
        status[ST_REFUSED_BIT] <= 1'b0;
      end
      if (burn_done_evt) begin
        status[ST_BURN_BIT] <= 1'b1;
      end
      if (erase_done_evt) begin
        status[ST_ERASE_BIT] <= 1'b1;
      end
      if (erase_refused_evt) begin
        status[ST_REFUSED_BIT] <= 1'b1;
      end
      irq_o <= status[ST_BURN_BIT] || status[ST_ERASE_BIT] || burn_done_evt || erase_done_evt;
    end
  end

endmodule

`default_nettype wire

/* test/flash_array_model.sv */
// Flash array model: answers reads with an address pattern, protection-sector reads with the index word, and ends burns and erases.
// Assumes the controller holds rd, prog and erase as levels on the shared clock.
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
  import flash_ctrl_pkg::*;
#(
  parameter logic [127:0] INDEX_WORD = 128'h5, // Access protection on, sector 1 secured.
  parameter int BUSY_CYCLES = 12
) (
  input wire logic clk_i, // System clock.
  input wire flash_ctrl_pkg::flash_req_t flash_i, // Request from the controller.
  output logic [127:0] rdata_o, // Read word.
  output logic done_o // Burn or erase finished.
);
  logic [127:0] junk = '0;
  int n = 0;
  // Outside a read the lines toggle, so stale data can never pass for a valid word.
  always_comb begin
    rdata_o = junk;
    if (flash_i.rd && flash_i.index) begin
      rdata_o = INDEX_WORD;
    end else if (flash_i.rd) begin
      for (int j = 0; j < 4; j++) rdata_o[32*j +: 32] = {flash_i.addr, 16'(j)};
    end
  end
  always @(posedge clk_i) begin
    junk <= ~junk;
    done_o <= 1'b0;
    if (!(flash_i.prog || flash_i.erase)) begin
      n <= 0;
    end else if (n == BUSY_CYCLES) begin
      done_o <= 1'b1;
      n <= 0;
    end else begin
      n <= n + 1;
    end
  end
endmodule
`default_nettype wire

/* test/flash_ctrl_checker.sv */
// Checker for the flash read buffer controller: timing relations seen at its ports.
// Assumes it is bound into the controller and sees nothing but the controller's ports.
`timescale 1ns/10ps
`default_nettype none
module flash_ctrl_checker
  import flash_ctrl_pkg::*;
#(
  parameter int INIT_COUNT = 10
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic hsel_i, // AHB select.
  input wire logic [1:0] htrans_i, // AHB transfer type.
  input wire logic hwrite_i, // AHB write flag.
  input wire logic hready_i, // AHB bus ready.
  input wire logic hready_o, // AHB slave ready.
  input wire flash_ctrl_pkg::flash_req_t flash_o, // Array request.
  input wire logic flash_done_i, // Array finished.
  input wire logic jtag_block_o, // Debug-port block.
  input wire logic debug_disable_o, // Processor debug off.
  input wire logic irq_o // Completion interrupt.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic take;
  logic seen_rd;
  int unsigned age;
  assign take = hsel_i && htrans_i[1] && hready_i && hready_o && !hwrite_i;
  // The age saturates so that a long run cannot wrap it back into the init window.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age <= 0;
    end else if (age < 100000) begin
      age <= age + 1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_rd <= 1'b0;
    end else if (flash_o.rd) begin
      seen_rd <= 1'b1;
    end
  end
  a_init_stall: assert property (take && age < INIT_COUNT |=> !hready_o)
    else $error("read answered during initialisation");
  a_index_first: assert property (flash_o.rd && !seen_rd |-> flash_o.index && flash_o.addr == INDEX_WORD_ADDR)
    else $error("first array read is not the protection word");
  a_index_len: assert property ($rose(flash_o.rd) && !seen_rd |-> flash_o.rd[*4])
    else $error("protection read shorter than the reset wait states");
  a_debug_pair: assert property (jtag_block_o == debug_disable_o)
    else $error("debug block and debug disable disagree");
  a_miss_launch: assert property (take && age > INIT_COUNT + 8 ##1 !hready_o |-> ##[0:40] flash_o.rd)
    else $error("stalled read without array read");
  a_miss_answer: assert property ($fell(hready_o) && age > INIT_COUNT + 8 |-> ##[1:60] hready_o)
    else $error("wait states never end");
  a_irq_done: assert property (flash_done_i |-> ##[0:2] irq_o)
    else $error("no interrupt after burn or erase");
  a_no_suspend: assert property ((flash_o.prog || flash_o.erase) && !flash_done_i |=> flash_o.prog || flash_o.erase)
    else $error("burn or erase dropped before done");
  c_miss: cover property (take ##1 !hready_o);
  c_hit: cover property (take ##1 hready_o);
  c_done: cover property (flash_done_i);
  c_abort: cover property (flash_o.abort);
endmodule
bind flash_read_buffer_controller flash_ctrl_checker #(.INIT_COUNT(INIT_COUNT)) u_checker (
  .clk_i, .rst_n_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hready_o, .flash_o, .flash_done_i,
  .jtag_block_o, .debug_disable_o, .irq_o
);
`default_nettype wire

/* test/flash_read_buffer_controller_tb.sv */
// Testbench for the flash read buffer controller: read modes, programming, protection, reset.
// Assumes the array model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module flash_read_buffer_controller_tb;
  import flash_ctrl_pkg::*;
  localparam int INIT_N = 10;
  localparam logic [31:0] A = 32'h2001_0040;
  typedef struct packed {
    logic [7:0] ctrl;
    logic hit_same;
    logic hit_next;
  } row_t;
  localparam row_t ROWS [5] = '{'{8'h01, 1'b0, 1'b0}, '{8'h03, 1'b1, 1'b0}, '{8'h05, 1'b1, 1'b1},
    '{8'h07, 1'b1, 1'b1}, '{8'h06, 1'b1, 1'b0}};
  logic clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] haddr_i = '0, pwdata_i = '0, hrdata_o, prdata_o, rd;
  logic [1:0] htrans_i = '0;
  logic [7:0] paddr_i = '0;
  logic hready_o, hresp_o, pready_o, pslverr_o, flash_done_i, jtag_block_o, debug_disable_o, irq_o, err;
  logic [127:0] flash_rdata_i;
  flash_req_t flash_o;
  int fail_count = 0, n_tests = 0, cyc = 0, w;
  flash_read_buffer_controller #(.INIT_COUNT(INIT_N)) u_dut (
    .clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i(1'b0), .hready_i(hready_o), .hrdata_o,
    .hready_o, .hresp_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .flash_o, .flash_rdata_i, .flash_done_i, .jtag_block_o, .debug_disable_o, .irq_o
  );
  flash_array_model u_array (.clk_i, .flash_i(flash_o), .rdata_o(flash_rdata_i), .done_o(flash_done_i));
  always #12.5 clk_i = ~clk_i;
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each transfer starts one edge after the call, so back-to-back calls never drive a signal twice in a step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (!pready_o);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic ahb(input logic [31:0] a);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= a;
    do @(posedge clk_i); while (!hready_o);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    w = 0;
    @(posedge clk_i);
    while (!hready_o) begin
      w++;
      @(posedge clk_i);
    end
    rd = hrdata_o;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (INIT_N + 20) @(posedge clk_i);
    // The model answers at once, so one wait state already exceeds its access time.
    apb(1'b1, OFS_WAIT, 32'h0000_0001);
    apb(1'b0, OFS_WAIT, '0);
    check(rd, 32'h0000_0001);
    foreach (ROWS[i]) begin
      apb(1'b1, OFS_CTRL, 32'(ROWS[i].ctrl));
      apb(1'b0, OFS_CTRL, '0);
      check(rd, 32'(ROWS[i].ctrl));
      ahb(A);
      check(rd, 32'h1004_0000);
      check(32'(w != 0), 32'h1);
      ahb(A + 4);
      check(rd, 32'h1004_0001);
      check(32'(w == 0), 32'(ROWS[i].hit_same));
      repeat (20) @(posedge clk_i);
      ahb(A + 16);
      check(rd, 32'h1005_0000);
      check(32'(w == 0), 32'(ROWS[i].hit_next));
    end
    apb(1'b0, OFS_LATCH0, '0);
    ahb(A + 20);
    check(32'(w != 0), 32'h1);
    ahb(32'h2000_2004);
    check(rd, '0);
    check(32'(hresp_o), 32'h0);
    apb(1'b0, 8'h40, '0);
    check(32'(err), 32'h1);
    for (int j = 0; j < 4; j++) apb(1'b1, OFS_LATCH0 + 8'(4 * j), 32'hABCD_0000 | 32'(j));
    apb(1'b1, OFS_PADDR, 32'h2001_0000);
    for (int c = 1; c <= 2; c++) begin
      apb(1'b1, OFS_CMD, 32'(c));
      apb(1'b1, OFS_CMD, 32'(c));
      check(32'(err), 32'h1);
      check(32'(flash_o.addr), 32'h0000_1000);
      if (c == 1) check(flash_o.wdata[127:96], 32'hABCD_0003);
      while (!irq_o) @(posedge clk_i);
      apb(1'b0, OFS_STATUS, '0);
      check(rd & 32'h0000_0003, 32'(c));
      apb(1'b1, OFS_STATUS, 32'(c));
      repeat (2) @(posedge clk_i);
      check(32'(irq_o), '0);
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0008);
    ahb(32'h2000_0000);
    check(rd, 32'h0000_0005);
    apb(1'b1, OFS_CMD, 32'h0000_0002);
    repeat (5) @(posedge clk_i);
    apb(1'b0, OFS_STATUS, '0);
    check(rd & 32'h0000_0020, 32'h0000_0020);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // A secured read stalled by start-up must still be refused once the security bits are known.
    ahb(32'h2000_2004);
    check(32'(w > INIT_N), 32'h1);
    check(rd, '0);
    ahb(A);
    check(rd, 32'h1004_0000);
    check(32'(jtag_block_o & debug_disable_o), 32'h1);
    apb(1'b0, OFS_CTRL, '0);
    check(rd, 32'h0000_0002);
    apb(1'b0, OFS_STATUS, '0);
    check(rd & 32'h0000_0018, 32'h0000_0018);
    report_and_stop();
  end
endmodule
`default_nettype wire
